// File: logic/amci_interp.sv
module amci_interp #(
	parameter logic [7:0] HW_REVISION = 8'h01 // Arbitrary value.
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Received characters from the serial receiver
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	// Characters to the serial transmitter
	output logic [7:0] tx_data_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	// Hardware register port
	output amci_pkg::amci_hw_acc_t hw_acc_out,
	output logic hw_stb_out
);

	// ==========================================================
	// State
	amci_pkg::amci_state_t state_q, state_d;
	logic [7:0] shadow_q [amci_pkg::NUM_REGS];
	logic [7:0] shadow_d [amci_pkg::NUM_REGS];
	logic [7:0] err_q, err_d;
	logic [1:0] fld_q, fld_d;
	logic in_fld_q, in_fld_d;
	logic [7:0] cmd_q, cmd_d;
	logic [7:0] fv_q [2];
	logic [7:0] fv_d [2];
	logic [1:0] fn_q [2];
	logic [1:0] fn_d [2];
	logic syn_q, syn_d;
	logic ovr_q, ovr_d;
	logic [5:0] cnt_q, cnt_d;
	logic zero_q, zero_d;
	amci_pkg::amci_hw_acc_t hw_q, hw_d;
	logic hw_stb_q, hw_stb_d;
	logic [7:0] txb_q [amci_pkg::TX_DEPTH];
	logic [7:0] txb_d [amci_pkg::TX_DEPTH];
	logic [2:0] txn_q, txn_d;
	logic lf_exec, e_syn, e_rng, cmd_ok;
	logic [7:0] uc;
	logic [4:0] hv;
	logic [7:0] ev;

	assign tx_data_out = txb_q[0];
	assign tx_valid_out = (state_q == amci_pkg::ST_TX);
	assign hw_acc_out = hw_q;
	assign hw_stb_out = hw_stb_q;

	// Decode of the line ending; letters are folded to upper case.
	always_comb begin
		uc = rx_data_in;
		if (rx_data_in >= 8'h61 && rx_data_in <= 8'h7A) begin
			uc = rx_data_in & 8'hDF;
		end
		hv = amci_pkg::hex_val(rx_data_in);
		lf_exec = (state_q == amci_pkg::ST_IDLE) && rx_valid_in &&
			(rx_data_in == amci_pkg::CH_LF);
		e_syn = syn_q;
		e_rng = 1'b0;
		if (fld_q == 2'd0) begin
			e_syn = 1'b1;
		end else begin
			unique case (cmd_q)
				amci_pkg::CMD_REG: begin
					if (fld_q != 2'd3 || fn_q[0] == 2'd1 ||
							fn_q[1] == 2'd1) begin
						e_syn = 1'b1;
					end
					if (fn_q[0] == 2'd3 || fn_q[1] == 2'd3 ||
							fv_q[0] > amci_pkg::MAX_REG_OFS) begin
						e_rng = 1'b1;
					end
				end
				amci_pkg::CMD_ERR, amci_pkg::CMD_INIT, amci_pkg::CMD_NULL,
				amci_pkg::CMD_UPD, amci_pkg::CMD_VER: begin
					if (fld_q != 2'd1) begin
						e_syn = 1'b1;
					end
				end
				default: e_syn = 1'b1;
			endcase
		end
		cmd_ok = !e_syn && !e_rng && !ovr_q;
		ev = (cmd_q == amci_pkg::CMD_VER) ? HW_REVISION : err_q;
	end

	// Next-state logic: parser, execution, hardware copy, reply shifter.
	always_comb begin
		state_d = state_q;
		shadow_d = shadow_q;
		err_d = err_q;
		fld_d = fld_q;
		in_fld_d = in_fld_q;
		cmd_d = cmd_q;
		fv_d = fv_q;
		fn_d = fn_q;
		syn_d = syn_q;
		ovr_d = ovr_q;
		cnt_d = cnt_q;
		zero_d = zero_q;
		hw_d = hw_q;
		hw_stb_d = 1'b0;
		txb_d = txb_q;
		txn_d = txn_q;
		// Bytes arriving while busy have nowhere to go.
		if (rx_valid_in && state_q != amci_pkg::ST_IDLE) begin
			err_d[amci_pkg::ERR_OVERRUN_BIT] = 1'b1;
			ovr_d = 1'b1;
		end
		unique case (state_q)
			amci_pkg::ST_IDLE: begin
				if (lf_exec) begin
					fld_d = 2'd0;
					in_fld_d = 1'b0;
					fv_d = '{8'h00, 8'h00}; // Stale fields must not leak.
					fn_d = '{2'd0, 2'd0};
					syn_d = 1'b0;
					ovr_d = 1'b0;
					txb_d[0] = amci_pkg::CH_READY;
					txn_d = amci_pkg::TX_PROMPT_ONLY;
					state_d = amci_pkg::ST_TX;
					if (!cmd_ok) begin
						txb_d[0] = amci_pkg::CH_FAIL;
						if (e_syn) begin
							err_d[amci_pkg::ERR_SYNTAX_BIT] = 1'b1;
						end
						if (e_rng) begin
							err_d[amci_pkg::ERR_LIMIT_BIT] = 1'b1;
						end
					end else begin
						unique case (cmd_q)
							amci_pkg::CMD_ERR, amci_pkg::CMD_VER: begin
								txb_d[0] = amci_pkg::hex_chr(ev[7:4]);
								txb_d[1] = amci_pkg::hex_chr(ev[3:0]);
								txb_d[2] = amci_pkg::CH_CR;
								txb_d[3] = amci_pkg::CH_LF;
								txb_d[4] = amci_pkg::CH_READY;
								txn_d = amci_pkg::TX_FULL_REPLY;
								if (cmd_q == amci_pkg::CMD_ERR) begin
									err_d = amci_pkg::ERR_RESET;
								end
							end
							amci_pkg::CMD_INIT: begin
								for (int i = 0; i < amci_pkg::NUM_REGS; i++) begin
									shadow_d[i] = amci_pkg::REG_RESET;
								end
								err_d = amci_pkg::ERR_RESET;
								zero_d = 1'b1;
								cnt_d = 6'h00;
								state_d = amci_pkg::ST_HW;
							end
							amci_pkg::CMD_UPD: begin
								zero_d = 1'b0;
								cnt_d = 6'h00;
								state_d = amci_pkg::ST_HW;
							end
							amci_pkg::CMD_REG: begin
								shadow_d[fv_q[0][4:0]] = fv_q[1];
							end
							default: begin
							end
						endcase
					end
				end else if (rx_valid_in) begin
					if (rx_data_in == amci_pkg::CH_SP ||
							rx_data_in == amci_pkg::CH_TAB) begin
						in_fld_d = 1'b0;
					end else if (rx_data_in >= amci_pkg::CH_SP &&
							rx_data_in != amci_pkg::CH_DEL) begin
						if (!in_fld_q) begin
							in_fld_d = 1'b1;
							if (fld_q == 2'd3) begin
								syn_d = 1'b1;
							end else begin
								fld_d = fld_q + 2'd1;
							end
							if (fld_q == 2'd0) begin
								cmd_d = uc;
							end else if (fld_q != 2'd3) begin
								fv_d[fld_q[1]] = {4'h0, hv[3:0]};
								fn_d[fld_q[1]] = 2'd1;
								syn_d = syn_q | !hv[4];
							end
						end else if (fld_q == 2'd1) begin
							syn_d = 1'b1;
						end else if (fld_q != 2'd0 && !syn_q) begin
							// Field 2 fills slot 0, field 3 slot 1; counts stop at 3.
							fv_d[fld_q[0]] = {fv_q[fld_q[0]][3:0], hv[3:0]};
							if (fn_q[fld_q[0]] != 2'd3) begin
								fn_d[fld_q[0]] = fn_q[fld_q[0]] + 2'd1;
							end
							syn_d = !hv[4];
						end
					end
				end
			end
			amci_pkg::ST_HW: begin
				// One hardware access per clock: the fastest possible copy.
				hw_stb_d = 1'b1;
				hw_d.addr = cnt_q;
				hw_d.data = zero_q ? amci_pkg::REG_RESET :
					shadow_q[cnt_q[4:0]];
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == amci_pkg::LAST_HW_STEP) begin
					hw_d.addr = amci_pkg::UPDATE_OFS;
					hw_d.data = amci_pkg::REG_RESET;
					txb_d[0] = amci_pkg::CH_READY;
					txn_d = amci_pkg::TX_PROMPT_ONLY;
					state_d = amci_pkg::ST_TX;
				end
			end
			amci_pkg::ST_TX: begin
				if (tx_ready_in) begin
					for (int i = 0; i < amci_pkg::TX_DEPTH - 1; i++) begin
						txb_d[i] = txb_q[i + 1];
					end
					txn_d = txn_q - 3'h1;
					if (txn_q == 3'h1) begin
						state_d = amci_pkg::ST_IDLE;
					end
				end
			end
			default: state_d = amci_pkg::ST_IDLE;
		endcase
	end

	// Registers; reset runs the power-on sequence of zeroes and update.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= amci_pkg::ST_HW;
			for (int i = 0; i < amci_pkg::NUM_REGS; i++) begin
				shadow_q[i] <= amci_pkg::REG_RESET;
			end
			err_q <= amci_pkg::ERR_RESET;
			fld_q <= 2'd0;
			in_fld_q <= 1'b0;
			cmd_q <= 8'h00;
			fv_q <= '{8'h00, 8'h00};
			fn_q <= '{2'd0, 2'd0};
			syn_q <= 1'b0;
			ovr_q <= 1'b0;
			cnt_q <= 6'h00;
			zero_q <= 1'b1;
			hw_q <= '0;
			hw_stb_q <= 1'b0;
			for (int i = 0; i < amci_pkg::TX_DEPTH; i++) begin
				txb_q[i] <= 8'h00;
			end
			txn_q <= 3'h0;
		end else begin
			state_q <= state_d;
			shadow_q <= shadow_d;
			err_q <= err_d;
			fld_q <= fld_d;
			in_fld_q <= in_fld_d;
			cmd_q <= cmd_d;
			fv_q <= fv_d;
			fn_q <= fn_d;
			syn_q <= syn_d;
			ovr_q <= ovr_d;
			cnt_q <= cnt_d;
			zero_q <= zero_d;
			hw_q <= hw_d;
			hw_stb_q <= hw_stb_d;
			txb_q <= txb_d;
			txn_q <= txn_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	chk_err_reply_first: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_ERR |=>
		tx_valid_out && tx_data_out == amci_pkg::hex_chr($past(err_q[7:4])))
		else $error("error reply does not start with flag hex");
	chk_err_flags_clear: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_ERR |=> err_q == 8'h00)
		else $error("error flags not cleared by query");
	chk_syntax_flag_set: assert property (
		lf_exec && e_syn |=> err_q[0])
		else $error("syntax flag not set");
	chk_limit_flag_set: assert property (
		lf_exec && e_rng |=> err_q[2])
		else $error("limit flag not set");
	chk_overrun_flag_set: assert property (
		rx_valid_in && state_q != amci_pkg::ST_IDLE |=> err_q[3])
		else $error("overrun flag not set");
	chk_init_zero_run: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_INIT |=>
		zero_q && err_q == 8'h00 ##1 hw_stb_out && hw_acc_out.data == 8'h00)
		else $error("initialize did not start zero copy");
	chk_null_prompt_only: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_NULL |=>
		tx_data_out == amci_pkg::CH_READY && txn_q == 3'h1 &&
		$stable(err_q) && !hw_stb_out)
		else $error("null command did more than prompt");
	chk_shadow_write_only: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_REG |=>
		shadow_q[$past(fv_q[0][4:0])] == $past(fv_q[1]) && !hw_stb_out)
		else $error("register write wrong");
	chk_update_strobe_end: assert property (
		lf_exec && cmd_ok && cmd_q == amci_pkg::CMD_UPD |->
		##34 hw_stb_out && hw_acc_out.addr == amci_pkg::UPDATE_OFS)
		else $error("update strobe not at offset 20");
	chk_fail_prompt_out: assert property (
		lf_exec && !cmd_ok |=> tx_valid_out &&
		tx_data_out == amci_pkg::CH_FAIL && txn_q == 3'h1)
		else $error("error prompt missing");

endmodule // amci_interp

// File: logic/amci_pkg.sv
// How it works
// - Error query replies two hex chars, CRLF, prompt.
// - Error query clears flags after capturing them.
// - Undecodable line sets flag bit 0.
// - Parameter_limit_flag parameter sets flag bit 2.
// - Receive overrun sets flag bit 3.
// - Initialize zeroes hardware, clears flags, prompts.
// - Null command only emits a ready prompt.
// - Write offset: two hex digits, 0 to 1F.
// - Write value: two hex digits, 0 to FF.
// - Register write touches only the shadow copy.
// - Update copies shadow, then strobes update location.
// - Version replies revision hex, CRLF, prompt.
// - Asterisk on success, question mark once on error.
// - Line-feed lines, blank-separated fields, controls ignored.
// - Offset 20 access strobes update, data irrelevant.
package amci_pkg;

	// ==========================================================
	// Hardware register map
	localparam int NUM_REGS = 32;
	localparam logic [5:0] UPDATE_OFS = 6'h20;
	localparam logic [7:0] MAX_REG_OFS = 8'h1F;
	localparam logic [5:0] LAST_HW_STEP = 6'h20;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Error flag fields
	localparam int ERR_SYNTAX_BIT = 0;
	localparam int ERR_LIMIT_BIT = 2;
	localparam int ERR_OVERRUN_BIT = 3;
	localparam logic [7:0] ERR_RESET = 8'h00;

	// ==========================================================
	// Characters and command letters
	localparam logic [7:0] CH_TAB = 8'h09;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_DEL = 8'h7F;
	localparam logic [7:0] CH_READY = 8'h2A;
	localparam logic [7:0] CH_FAIL = 8'h3F;
	localparam logic [7:0] CMD_ERR = 8'h45;
	localparam logic [7:0] CMD_INIT = 8'h49;
	localparam logic [7:0] CMD_NULL = 8'h4E;
	localparam logic [7:0] CMD_REG = 8'h52;
	localparam logic [7:0] CMD_UPD = 8'h55;
	localparam logic [7:0] CMD_VER = 8'h56;
	localparam int TX_DEPTH = 5;
	localparam logic [2:0] TX_FULL_REPLY = 3'h5;
	localparam logic [2:0] TX_PROMPT_ONLY = 3'h1;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HW = 3'b010,
		ST_TX = 3'b100
	} amci_state_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data;
	} amci_hw_acc_t;

	// Returns {valid, nibble} for an ASCII hex digit of either case.
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= 8'h30 && c <= 8'h39) begin
			r = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) ||
				(c >= 8'h61 && c <= 8'h66)) begin
			r = {1'b1, c[3:0] + 4'h9};
		end
		return r;
	endfunction

	// Uppercase ASCII for one nibble.
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		logic [7:0] r;
		r = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
		return r;
	endfunction

endpackage

// File: verification/amci_host.sv
module amci_host (
	// Clock
	input wire logic clk_in,
	// Characters toward the interpreter
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	// Characters from the interpreter
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic slow;
	logic [63:0] reply;
	logic [3:0] tick;

	// Idle values at time zero.
	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
		slow = 1'b0;
		reply = 64'h0;
		tick = 4'h0;
	end

	// Slow mode takes one character in four, so held tx data is stressed.
	always @(negedge clk_in) begin
		tick <= tick + 4'h1;
		tx_ready_out <= !slow || (tick[1:0] == 2'h3);
	end

	// Every character taken is shifted into the reply record.
	always @(posedge clk_in) begin
		if (tx_valid_in && tx_ready_out) begin
			reply <= {reply[55:0], tx_data_in};
		end
	end

	// Characters go out back to back; the idle line shows the inverse.
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge clk_in);
			rx_data_out = s[i];
			rx_valid_out = 1'b1;
		end
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		rx_data_out = ~rx_data_out;
	endtask

	// A new line is only sent after a prompt has arrived or 3000 cycles have passed without one.
	task automatic wait_prompt();
		int n;
		n = 0;
		while (reply[7:0] !== 8'h2A && reply[7:0] !== 8'h3F && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
	endtask

	// One full command exchange.
	task automatic line(input string s);
		reply = 64'h0;
		send(s);
		wait_prompt();
	endtask
endmodule // amci_host

// File: verification/amci_interp_tb.sv
module amci_interp_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] rx_data, tx_data;
	logic rx_valid, tx_valid, tx_ready, hw_stb;
	amci_pkg::amci_hw_acc_t hw_acc;
	amci_pkg::amci_hw_acc_t hwq[$];
	int stamp[$];
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] shadow [32];
	string cmd [17] = '{"N\n", "n \t\001\177\n", "R 1F AB\n", "r\t03  3c\n",
		"R 03 5\n", "E\n", "E\n", "R 20 00\n", "e\n", "R 00 123\n", "E\n",
		"Q\n", "\n", "NN\n", "R 1F\n", "E\n", "V\n"};
	string rep [17] = '{"*", "*", "*", "*", "?", "01\r\n*", "00\r\n*", "?",
		"04\r\n*", "?", "04\r\n*", "?", "?", "?", "?", "01\r\n*", "A5\r\n*"};

	// ==========================================================
	// Clock, design and host
	initial begin
		forever #10 clk_in = ~clk_in;
	end

	amci_interp #(.HW_REVISION(8'hA5)) u_dut (.clk_in(clk_in),
		.srst_in(srst_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid),
		.tx_ready_in(tx_ready), .hw_acc_out(hw_acc), .hw_stb_out(hw_stb));

	amci_host u_host (.clk_in(clk_in), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid), .tx_data_in(tx_data),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

	// Hardware accesses are logged with their cycle; a hang is cut off.
	always @(posedge clk_in) begin
		cycles++;
		if (hw_stb) begin
			hwq.push_back(hw_acc);
			stamp.push_back(cycles);
		end
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	// ==========================================================
	// Checking tasks
	task automatic check(input string name, input logic [63:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [63:0] pack(input string s);
		logic [63:0] r;
		r = 64'h0;
		for (int i = 0; i < s.len(); i++) begin
			r = {r[55:0], s[i]};
		end
		return r;
	endfunction

	// A full copy is 32 shadow writes in order, then the update location.
	task automatic chk_copy();
		check("strobes", 64'(hwq.size()), 64'd33);
		for (int i = 0; i < hwq.size() && i < 33; i++) begin
			check("addr", 64'(hwq[i].addr),
				64'((i < 32) ? 6'(i) : amci_pkg::UPDATE_OFS));
			if (i < 32) begin
				check("data", 64'(hwq[i].data), 64'(shadow[i]));
			end
		end
		if (hwq.size() > 0) begin
			check("span", 64'(stamp[$] - stamp[0]), 64'd32);
		end
		hwq.delete();
		stamp.delete();
	endtask

	task automatic run(input string c, input string r);
		u_host.line(c);
		check("reply", u_host.reply, pack(r));
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (4) @(negedge clk_in);
		srst_in = 1'b0;
		u_host.wait_prompt();
		check("boot", u_host.reply, pack("*"));
		chk_copy();
		// Table rows; odd rows run with a stalling host.
		foreach (cmd[i]) begin
			u_host.slow = i[0];
			run(cmd[i], rep[i]);
			check("no hw", 64'(hwq.size()), 64'd0);
		end
		u_host.slow = 1'b0;
		shadow[31] = 8'hAB;
		shadow[3] = 8'h3C;
		run("U\n", "*");
		chk_copy();
		// Characters during the copy overrun; the next line must fail.
		u_host.reply = 64'h0;
		u_host.send("U\n   NN\n");
		u_host.wait_prompt();
		check("busy", u_host.reply, pack("*"));
		chk_copy();
		run("N\n", "?");
		run("E\n", "08\r\n*");
		run("Z\n", "?");
		run("I\n", "*");
		foreach (shadow[i]) shadow[i] = 8'h00;
		chk_copy();
		run("E\n", "00\r\n*");
		run("U\n", "*");
		chk_copy();
		// Reset in mid-run: the shadow is lost and the power-on copy reruns.
		run("R 05 77\n", "*");
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		u_host.reply = 64'h0;
		srst_in = 1'b0;
		u_host.wait_prompt();
		check("reset", u_host.reply, pack("*"));
		chk_copy();
		run("U\n", "*");
		chk_copy();
		run("E\n", "00\r\n*");
		conclude();
	end
endmodule // amci_interp_tb
